/* inc/dpcu_pkg.sv */
package dpcu_pkg;

    localparam int DPCU_NUM_CH = 2;

    // Register addresses, one word per parameter address
    localparam logic [15:0] DPCU_OFS_STATUS = 16'h0a02;
    localparam logic [15:0] DPCU_OFS_EDGE1 = 16'h0a04;
    localparam logic [15:0] DPCU_OFS_EDGE2 = 16'h0a06;
    localparam logic [15:0] DPCU_OFS_ACT1 = 16'h0a08;
    localparam logic [15:0] DPCU_OFS_ACT2 = 16'h0a0a;
    localparam logic [15:0] DPCU_OFS_POS1 = 16'h0a0c;
    localparam logic [15:0] DPCU_OFS_POS2 = 16'h0a0e;
    localparam logic [15:0] DPCU_OFS_TALLY1 = 16'h0a10;
    localparam logic [15:0] DPCU_OFS_TALLY2 = 16'h0a12;

    // Activation codes as written by the fieldbus master
    localparam logic [31:0] DPCU_ACT_CANCEL = 32'h0000_0000;
    localparam logic [31:0] DPCU_ACT_ONCE = 32'h0000_0001;
    localparam logic [31:0] DPCU_ACT_CONT = 32'h0000_0002;

    // Edge codes
    localparam logic [31:0] DPCU_EDGE_FALL = 32'h0000_0000;
    localparam logic [31:0] DPCU_EDGE_RISE = 32'h0000_0001;

    // Status bit positions
    localparam int DPCU_STAT_CH1_BIT = 0;
    localparam int DPCU_STAT_CH2_BIT = 1;

    // Values after reset
    localparam logic DPCU_EDGE_RESET = 1'b0;
    localparam logic [1:0] DPCU_ACT_RESET = 2'h0;
    localparam logic [15:0] DPCU_TALLY_RESET = 16'h0000;
    localparam logic [31:0] DPCU_POS_RESET = 32'h0000_0000;
    localparam logic [31:0] DPCU_RDATA_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        DPCU_MODE_OFF = 2'b00,
        DPCU_MODE_ONCE = 2'b01,
        DPCU_MODE_CONT = 2'b10
    } dpcu_mode_t;

endpackage

/* design/dpcu_trigger_sync.sv */
`timescale 1ns/1ps
module dpcu_trigger_sync
    import dpcu_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic pin_in,
    input wire logic rising_sel_in,
    output logic edge_out
);

    logic stage1;
    logic stage2;
    logic stage3;
    logic level;

    // Change counts only once the second and third stage agree
    wire agree = (stage2 == stage3);
    wire went_high = agree && stage3 && !level;
    wire went_low = agree && !stage3 && level;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            level <= 1'b0;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            if (agree) begin
                level <= stage3;
            end
        end
    end

    // Select applies combinationally, so a change acts at once
    assign edge_out = rising_sel_in ? went_high : went_low; // [R10]

endmodule

/* design/dpcu_capture_channel.sv */
`timescale 1ns/1ps
module dpcu_capture_channel
    import dpcu_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic edge_in,
    input wire logic start_once_in,
    input wire logic start_cont_in,
    input wire logic cancel_in,
    input wire logic signed [31:0] position_in,
    input wire logic rebase_strobe_in,
    input wire logic signed [31:0] rebase_offset_in,
    output logic flag_out,
    output logic signed [31:0] position_out,
    output logic [15:0] tally_out,
    output dpcu_mode_t mode_out
);

    dpcu_mode_t next_mode;

    wire start = start_once_in || start_cont_in;
    // A start arms the channel in the same cycle; a cancel still
    // lets a coincident edge count under the old mode
    wire hit = edge_in && (start || (mode_out != DPCU_MODE_OFF)); // [R2] [R3]

    always_comb begin
        next_mode = mode_out;
        case (mode_out)
            DPCU_MODE_OFF: next_mode = DPCU_MODE_OFF;
            DPCU_MODE_ONCE: next_mode = hit ? DPCU_MODE_OFF : DPCU_MODE_ONCE; // [R2]
            DPCU_MODE_CONT: next_mode = DPCU_MODE_CONT; // [R3]
            default: next_mode = DPCU_MODE_OFF;
        endcase
        if (start_once_in) begin
            next_mode = hit ? DPCU_MODE_OFF : DPCU_MODE_ONCE; // [R1] [R4]
        end else if (start_cont_in) begin
            next_mode = DPCU_MODE_CONT; // [R1] [R4]
        end else if (cancel_in) begin
            next_mode = DPCU_MODE_OFF; // [R1] [R4]
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_out <= DPCU_MODE_OFF;
        end else begin
            mode_out <= next_mode;
        end
    end

    // Set wins over the clear of a coincident activation
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flag_out <= 1'b0;
        end else if (hit) begin
            flag_out <= 1'b1; // [R11]
        end else if (start || cancel_in) begin
            flag_out <= 1'b0; // [R11]
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tally_out <= DPCU_TALLY_RESET;
        end else if (start) begin
            tally_out <= hit ? 16'h0001 : 16'h0000; // [R9]
        end else if (hit) begin
            tally_out <= tally_out + 16'h0001; // [R8]
        end
    end

    // Fresh capture is already in the new reference, so it wins
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            position_out <= DPCU_POS_RESET;
        end else if (hit) begin
            position_out <= position_in; // [R6]
        end else if (rebase_strobe_in) begin
            position_out <= position_out + rebase_offset_in; // [R7]
        end
    end

endmodule

/* design/dpcu_capture_unit.sv */
`timescale 1ns/1ps
// Operation
// [R1] Activation value 0 cancels, 1 starts one-time, 2 starts continuous capture.
// [R2] One-time mode stops itself after first latched position, ignoring later edges.
// [R3] Continuous mode latches the position on every qualifying edge until cancelled.
// [R4] Activation writes act at once, without waiting for any motion event.
// [R5] Read-only 16-bit status word: bit 0 channel one, bit 1 channel two.
// [R6] Each capture stores the present signed 32-bit motor position per channel.
// [R7] Stored positions are shifted when the position reference is redefined.
// [R8] Each channel keeps a 16-bit counter of its capture events.
// [R9] Activating a channel clears its event counter to zero.
// [R10] Per-channel edge select: 0 falling, 1 rising, effective immediately.
// [R11] Status flag sets on first capture, clears on activation or cancel.
module dpcu_capture_unit
    import dpcu_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic trigger_input_one_in,
    input wire logic trigger_input_two_in,
    input wire logic signed [31:0] motor_position_in,
    input wire logic rebase_strobe_in,
    input wire logic signed [31:0] rebase_offset_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_wdata_in,
    output logic [31:0] reg_rdata_out,
    output logic reg_ack_out,
    output logic reg_err_out
);

    logic [DPCU_NUM_CH-1:0] edge_sel;
    logic [1:0] act_value [DPCU_NUM_CH];
    logic [DPCU_NUM_CH-1:0] cap_flag;
    logic signed [31:0] cap_pos [DPCU_NUM_CH];
    logic [15:0] cap_tally [DPCU_NUM_CH];
    logic [DPCU_NUM_CH-1:0] cap_edge;

    wire [DPCU_NUM_CH-1:0] trig_pins = {trigger_input_two_in, trigger_input_one_in};

    // Address decode
    wire hit_status = (reg_addr_in == DPCU_OFS_STATUS);
    wire hit_edge1 = (reg_addr_in == DPCU_OFS_EDGE1);
    wire hit_edge2 = (reg_addr_in == DPCU_OFS_EDGE2);
    wire hit_act1 = (reg_addr_in == DPCU_OFS_ACT1);
    wire hit_act2 = (reg_addr_in == DPCU_OFS_ACT2);
    wire hit_pos1 = (reg_addr_in == DPCU_OFS_POS1);
    wire hit_pos2 = (reg_addr_in == DPCU_OFS_POS2);
    wire hit_tally1 = (reg_addr_in == DPCU_OFS_TALLY1);
    wire hit_tally2 = (reg_addr_in == DPCU_OFS_TALLY2);

    wire [DPCU_NUM_CH-1:0] hit_edge = {hit_edge2, hit_edge1};
    wire [DPCU_NUM_CH-1:0] hit_act = {hit_act2, hit_act1};

    wire hit_ro = hit_status || hit_pos1 || hit_pos2 || hit_tally1 || hit_tally2;
    wire hit_rw = hit_edge1 || hit_edge2 || hit_act1 || hit_act2;
    wire mapped = hit_ro || hit_rw;

    // Value range checks; out-of-range writes leave the register alone
    wire act_is_cancel = (reg_wdata_in == DPCU_ACT_CANCEL);
    wire act_is_once = (reg_wdata_in == DPCU_ACT_ONCE);
    wire act_is_cont = (reg_wdata_in == DPCU_ACT_CONT);
    wire act_legal = act_is_cancel || act_is_once || act_is_cont;
    wire edge_legal = (reg_wdata_in == DPCU_EDGE_FALL) || (reg_wdata_in == DPCU_EDGE_RISE);

    wire edge_wr_ok = reg_wr_in && (hit_edge1 || hit_edge2) && edge_legal;
    wire act_wr_ok = reg_wr_in && (hit_act1 || hit_act2) && act_legal;

    wire wr_bad = reg_wr_in && (!mapped || hit_ro
                  || ((hit_edge1 || hit_edge2) && !edge_legal)
                  || ((hit_act1 || hit_act2) && !act_legal));
    wire rd_bad = reg_rd_in && !mapped;

    // Read selection
    wire [15:0] status_word = {14'h0000, cap_flag[1], cap_flag[0]}; // [R5]
    wire [31:0] rd_mux =
        hit_status ? {16'h0000, status_word} : // [R5]
        hit_edge1 ? {31'h0000_0000, edge_sel[0]} :
        hit_edge2 ? {31'h0000_0000, edge_sel[1]} :
        hit_act1 ? {30'h0000_0000, act_value[0]} :
        hit_act2 ? {30'h0000_0000, act_value[1]} :
        hit_pos1 ? cap_pos[0] :
        hit_pos2 ? cap_pos[1] :
        hit_tally1 ? {16'h0000, cap_tally[0]} :
        hit_tally2 ? {16'h0000, cap_tally[1]} :
        32'h0000_0000;

    genvar ch;
    generate
        for (ch = 0; ch < DPCU_NUM_CH; ch++) begin : g_ch
            wire act_here = act_wr_ok && hit_act[ch];

            always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    edge_sel[ch] <= DPCU_EDGE_RESET;
                end else if (edge_wr_ok && hit_edge[ch]) begin
                    edge_sel[ch] <= reg_wdata_in[0]; // [R10]
                end
            end

            // Readback keeps the last accepted code, even after a one-time
            // capture has ended; the live mode is not visible here
            always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    act_value[ch] <= DPCU_ACT_RESET;
                end else if (act_here) begin
                    act_value[ch] <= reg_wdata_in[1:0];
                end
            end

            // Three stage synchroniser adds latency before the position
            // is sampled; at full speed this is a few tens of ns
            dpcu_trigger_sync u_sync (
                .clk_sys_in(clk_sys_in),
                .rst_n_in(rst_n_in),
                .pin_in(trig_pins[ch]),
                .rising_sel_in(edge_sel[ch]),
                .edge_out(cap_edge[ch])
            );

            dpcu_capture_channel u_chan (
                .clk_sys_in(clk_sys_in),
                .rst_n_in(rst_n_in),
                .edge_in(cap_edge[ch]),
                .start_once_in(act_here && act_is_once), // [R1]
                .start_cont_in(act_here && act_is_cont), // [R1]
                .cancel_in(act_here && act_is_cancel), // [R1]
                .position_in(motor_position_in),
                .rebase_strobe_in(rebase_strobe_in),
                .rebase_offset_in(rebase_offset_in),
                .flag_out(cap_flag[ch]),
                .position_out(cap_pos[ch]),
                .tally_out(cap_tally[ch]),
                .mode_out()
            );
        end
    endgenerate

    // One cycle answer to every read or write
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= DPCU_RDATA_RESET;
            reg_ack_out <= 1'b0;
            reg_err_out <= 1'b0;
        end else begin
            reg_ack_out <= reg_rd_in || reg_wr_in;
            reg_err_out <= rd_bad || wr_bad;
            if (reg_rd_in) begin
                reg_rdata_out <= rd_mux;
            end
        end
    end

endmodule

/* verification/dpcu_sensor_model.sv */
`timescale 1ns/1ps
module dpcu_sensor_model (
    input wire logic clk_sys_in,
    output logic trigger_input_one_out,
    output logic trigger_input_two_out
);
    logic [1:0] pins = 2'h0;
    // Push-pull sensor, so the idle level is always driven low
    assign trigger_input_one_out = pins[0];
    assign trigger_input_two_out = pins[1];
    // Hold gives prompt or slow pulses, never under the 2-cycle filter minimum
    task automatic pulse(input int ch, input int hold);
        @(posedge clk_sys_in);
        #1;
        pins[ch] = 1'b1;
        repeat (hold) @(posedge clk_sys_in);
        #1;
        pins[ch] = 1'b0;
        repeat (hold + 3) @(posedge clk_sys_in);
        // Return off the edge so callers never race the clock
        #1;
    endtask
endmodule

/* verification/dpcu_capture_unit_chk.sv */
`timescale 1ns/1ps
module dpcu_capture_unit_chk
    import dpcu_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic reg_ack_out,
    input wire logic reg_err_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    wire req = reg_rd_in | reg_wr_in;
    wire act_wr = reg_wr_in && (reg_addr_in == DPCU_OFS_ACT1 || reg_addr_in == DPCU_OFS_ACT2);
    AST_ACK_AFTER_REQ: assert property (req |=> reg_ack_out) else $error("ack missing");
    AST_NO_SPURIOUS_ACK: assert property (!req |=> !reg_ack_out && !reg_err_out) else $error("stray ack");
    AST_RDATA_HOLDS: assert property (!reg_rd_in |=> $stable(reg_rdata_out)) else $error("rdata moved");
    AST_STATUS_RO: assert property (reg_wr_in && reg_addr_in == DPCU_OFS_STATUS |=> reg_err_out) else $error("status written");
    AST_STATUS_WIDTH: assert property (reg_rd_in && reg_addr_in == DPCU_OFS_STATUS |=> reg_rdata_out[31:2] == 30'h0) else $error("status bits");
    AST_POS_RO: assert property (reg_wr_in && reg_addr_in == DPCU_OFS_POS1 |=> reg_err_out) else $error("position written");
    AST_ACT_RANGE: assert property (act_wr && reg_wdata_in > DPCU_ACT_CONT |=> reg_err_out) else $error("bad code taken");
    AST_ACT_ACCEPT: assert property (act_wr && reg_wdata_in <= DPCU_ACT_CONT |=> !reg_err_out) else $error("code refused");
    AST_EDGE_RANGE: assert property (reg_wr_in && reg_addr_in == DPCU_OFS_EDGE1 && reg_wdata_in > 32'h1 |=> reg_err_out) else $error("bad edge taken");
    AST_TALLY_WIDTH: assert property (reg_rd_in && reg_addr_in == DPCU_OFS_TALLY1 |=> reg_rdata_out[31:16] == 16'h0) else $error("tally width");
    cover property (act_wr && reg_wdata_in == DPCU_ACT_ONCE);
    cover property (act_wr && reg_wdata_in == DPCU_ACT_CONT);
    cover property (reg_err_out);
endmodule
bind dpcu_capture_unit dpcu_capture_unit_chk i_chk (.clk_sys_in, .rst_n_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
    .reg_wdata_in, .reg_rdata_out, .reg_ack_out, .reg_err_out);

/* verification/dual_position_capture_unit_tb.sv */
`timescale 1ns/1ps
module dual_position_capture_unit_tb;
    import dpcu_pkg::*;
    logic clk_sys_in = 1'h0;
    logic rst_n_in = 1'h0;
    logic [15:0] reg_addr_in = 16'h0;
    logic reg_wr_in = 1'h0;
    logic reg_rd_in = 1'h0;
    logic [31:0] reg_wdata_in = 32'h0;
    logic signed [31:0] motor_position_in = 32'h0;
    logic rebase_strobe_in = 1'h0;
    logic signed [31:0] rebase_offset_in = 32'h0;
    logic t1, t2, reg_ack_out, reg_err_out;
    logic [31:0] reg_rdata_out;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    always #5 clk_sys_in = ~clk_sys_in;
    dpcu_sensor_model i_sen (.clk_sys_in, .trigger_input_one_out(t1), .trigger_input_two_out(t2));
    dpcu_capture_unit i_dut (.clk_sys_in, .rst_n_in, .trigger_input_one_in(t1), .trigger_input_two_in(t2),
        .motor_position_in, .rebase_strobe_in, .rebase_offset_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
        .reg_wdata_in, .reg_rdata_out, .reg_ack_out, .reg_err_out);
    task automatic end_of_test();
        if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic err);
        @(posedge clk_sys_in);
        #1;
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = wr;
        reg_rd_in = !wr;
        @(posedge clk_sys_in);
        #1;
        reg_wr_in = 1'h0;
        reg_rd_in = 1'h0;
        chk({30'h0, reg_ack_out, reg_err_out}, {30'h0, 1'h1, err});
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic err);
        bus(1'h0, a, 32'h0, err);
        chk(reg_rdata_out, exp);
    endtask
    task automatic t_refuse();
        rd(DPCU_OFS_STATUS, 32'h0, 1'h0);
        rd(DPCU_OFS_TALLY1, 32'h0, 1'h0);
        bus(1'h1, DPCU_OFS_STATUS, 32'h3, 1'h1);
        bus(1'h1, DPCU_OFS_POS1, 32'h1, 1'h1);
        bus(1'h1, DPCU_OFS_ACT1, 32'h3, 1'h1);
        bus(1'h1, DPCU_OFS_EDGE1, 32'h2, 1'h1);
        rd(16'h0a20, 32'h0, 1'h1);
    endtask
    task automatic t_once();
        bus(1'h1, DPCU_OFS_EDGE1, DPCU_EDGE_RISE, 1'h0);
        bus(1'h1, DPCU_OFS_ACT1, DPCU_ACT_ONCE, 1'h0);
        motor_position_in = 32'hfff0_0010;
        i_sen.pulse(0, 3);
        rd(DPCU_OFS_STATUS, 32'h1, 1'h0);
        rd(DPCU_OFS_POS1, 32'hfff0_0010, 1'h0);
        motor_position_in = 32'h0000_0777;
        i_sen.pulse(0, 8);
        rd(DPCU_OFS_POS1, 32'hfff0_0010, 1'h0);
        rd(DPCU_OFS_TALLY1, 32'h1, 1'h0);
        rd(DPCU_OFS_EDGE1, DPCU_EDGE_RISE, 1'h0);
        rd(DPCU_OFS_ACT1, DPCU_ACT_ONCE, 1'h0);
    endtask
    // Channel two stays on the falling edge left by reset
    task automatic t_cont();
        rd(DPCU_OFS_EDGE2, DPCU_EDGE_FALL, 1'h0);
        bus(1'h1, DPCU_OFS_ACT2, DPCU_ACT_CONT, 1'h0);
        for (int i = 1; i <= 3; i++) begin
            motor_position_in = 32'h0000_1000 * i;
            i_sen.pulse(1, 2 + 3 * i);
        end
        rd(DPCU_OFS_TALLY2, 32'h3, 1'h0);
        rd(DPCU_OFS_POS2, 32'h0000_3000, 1'h0);
        rd(DPCU_OFS_STATUS, 32'h3, 1'h0);
    endtask
    task automatic t_rebase();
        @(posedge clk_sys_in);
        #1;
        rebase_strobe_in = 1'h1;
        rebase_offset_in = 32'h0000_0100;
        @(posedge clk_sys_in);
        #1;
        rebase_strobe_in = 1'h0;
        rd(DPCU_OFS_POS1, 32'hfff0_0110, 1'h0);
        rd(DPCU_OFS_POS2, 32'h0000_3100, 1'h0);
    endtask
    task automatic t_restart();
        bus(1'h1, DPCU_OFS_ACT2, DPCU_ACT_ONCE, 1'h0);
        rd(DPCU_OFS_TALLY2, 32'h0, 1'h0);
        rd(DPCU_OFS_STATUS, 32'h1, 1'h0);
        // Flag must be set again before the cancel can show it clears
        motor_position_in = 32'h0000_0abc;
        i_sen.pulse(1, 3);
        rd(DPCU_OFS_STATUS, 32'h3, 1'h0);
        rd(DPCU_OFS_POS2, 32'h0000_0abc, 1'h0);
        bus(1'h1, DPCU_OFS_ACT2, DPCU_ACT_CANCEL, 1'h0);
        rd(DPCU_OFS_STATUS, 32'h1, 1'h0);
        i_sen.pulse(1, 3);
        rd(DPCU_OFS_TALLY2, 32'h1, 1'h0);
        rd(DPCU_OFS_STATUS, 32'h1, 1'h0);
    endtask
    // Ceiling well above the roughly 190 cycles the scenarios need
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            end_of_test();
        end
    end
    initial begin
        repeat (16) @(posedge clk_sys_in);
        #1;
        rst_n_in = 1'h1;
        t_refuse();
        t_once();
        t_cont();
        t_rebase();
        t_restart();
        end_of_test();
    end
endmodule
